// *** bench/agsd_board.sv ***
// board straps and host gain settings
`timescale 1ns/100ps
module agsd_board
  import agsd_pkg::*;
(
  // strap code from the bench
  input logic [1:0] code,
  // pins and host gains
  output logic hi,
  output logic lo,
  output logic [9:0] boost,
  output logic [9:0] vol,
  output logic [9:0] ana
);
  assign {hi, lo} = code;
  // host sets boost once and never touches it
  assign boost = 10'h014;
  assign vol = 10'h00a;
  assign ana = 10'h0c8;
endmodule // agsd_board

// *** bench/agsd_top_props.sv ***
// assertions on the gain strap decoder ports
`timescale 1ns/100ps
module agsd_top_props
  import agsd_pkg::*;
(
  input logic clock,
  input logic sys_rst,
  input logic gain_select_strap_high,
  input logic gain_select_strap_low,
  input logic mono_mode_or_serial_clock_pin,
  input logic switch_rate_or_serial_data_pin,
  input agsd_mode_t mode,
  input agsd_gain_t gain,
  input logic [9:0] digital_volume,
  input logic ctrl_scl_in,
  input logic ctrl_sda_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire [1:0] code = {gain_select_strap_high, gain_select_strap_low};
  // four edges covers the sync stages plus output register
  sequence held(logic [1:0] c);
    (code == c) [*4];
  endsequence
  // software code held three samples, then left
  sequence left_sw;
    (code == 2'h3) [*3] ##1 (code != 2'h3);
  endsequence
  chk_hw_mode: assert property (
    held(2'h0) |=> mode == AGSD_MODE_HW)
    else $error("hw mode missing");
  chk_sw_mode: assert property (
    held(2'h3) |=> mode == AGSD_MODE_SW)
    else $error("sw mode missing");
  chk_ana_low: assert property (
    held(2'h0) |=> gain.analog_stage_gain == AGSD_ANA_LOW_DT)
    else $error("low gain wrong");
  chk_ana_mid: assert property (
    held(2'h1) |=> gain.analog_stage_gain == AGSD_ANA_MID_DT)
    else $error("mid gain wrong");
  chk_ana_high: assert property (
    held(2'h2) |=> gain.analog_stage_gain == AGSD_ANA_HIGH_DT)
    else $error("high gain wrong");
  chk_boost_fixed: assert property (
    mode == AGSD_MODE_HW |-> gain.digital_path_gain == AGSD_BOOST_DT)
    else $error("boost not fixed");
  chk_volume_fixed: assert property (
    mode == AGSD_MODE_HW |-> digital_volume == AGSD_VOLUME_RST_DT)
    else $error("volume moved");
  chk_total_sum: assert property (
    gain.total_gain ==
      10'(gain.digital_path_gain + gain.analog_stage_gain))
    else $error("total not sum");
  chk_pin_route: assert property (
    mode == AGSD_MODE_SW |-> {ctrl_scl_in, ctrl_sda_in} ==
      {mono_mode_or_serial_clock_pin, switch_rate_or_serial_data_pin})
    else $error("pins not routed");
  chk_ctrl_idle: assert property (
    mode == AGSD_MODE_HW |-> ctrl_scl_in && ctrl_sda_in)
    else $error("control lines not idle");
  chk_sync_delay: assert property (
    left_sw |=> mode == AGSD_MODE_SW)
    else $error("mode left too early");
endmodule // agsd_top_props
bind agsd_top agsd_top_props u_chk (.*);

// *** bench/tb_top.sv ***
// self-checking bench for the gain strap decoder
`timescale 1ns/100ps
module tb_top;
  import agsd_pkg::*;
  typedef struct {logic [1:0] c; agsd_mode_t m; agsd_gain_t g;} agsd_row_t;
  logic clock = 0, sys_rst = 1, hi, lo, mono = 1, data = 0, scl, sda;
  logic mono_en, rate_low;
  logic [1:0] code = 2'h0;
  logic [9:0] boost, vol_in, ana, vol;
  agsd_mode_t mode;
  agsd_gain_t gain;
  int fails = 0, tests_run = 0, cyc = 0;
  agsd_row_t rows [4] = '{'{2'h0, AGSD_MODE_HW, '{10'h03c, 10'h0c0, 10'h0fc}},
    '{2'h1, AGSD_MODE_HW, '{10'h03c, 10'h0e2, 10'h11e}},
    '{2'h2, AGSD_MODE_HW, '{10'h03c, 10'h0fa, 10'h136}},
    '{2'h3, AGSD_MODE_SW, '{10'h01e, 10'h0c8, 10'h0e6}}};
  agsd_board board (.code(code), .hi(hi), .lo(lo), .boost(boost),
    .vol(vol_in), .ana(ana));
  agsd_top dut (.clock(clock), .sys_rst(sys_rst),
    .gain_select_strap_high(hi), .gain_select_strap_low(lo),
    .mono_mode_or_serial_clock_pin(mono),
    .switch_rate_or_serial_data_pin(data), .sw_digital_boost(boost),
    .sw_digital_volume(vol_in), .sw_analog_gain(ana), .mode(mode),
    .gain(gain), .digital_volume(vol), .mono_mode_enable(mono_en),
    .switch_rate_low(rate_low), .ctrl_scl_in(scl), .ctrl_sda_in(sda));
  always #10 clock = ~clock;
  task automatic chk(logic [29:0] seen, logic [29:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 400) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    @(negedge clock);
    chk(gain, {10'h03c, 10'h0c0, 10'h0fc});
    chk(mode, AGSD_MODE_HW);
    chk(vol, 10'h000);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clock) code <= rows[i].c;
      repeat (5) @(negedge clock);
      chk(mode, rows[i].m);
      chk(gain, rows[i].g);
      chk(vol, rows[i].c == 2'h3 ? 10'h00a : 10'h000);
      chk({mono_en, rate_low, scl, sda}, rows[i].m == AGSD_MODE_SW ?
        {2'b00, mono, data} : {mono, ~data, 2'b11});
      $display("code %h test done", rows[i].c);
    end
    chk({scl, sda}, {mono, data});
    // old mode must linger through the sync stages
    @(posedge clock) code <= 2'h2;
    repeat (3) @(negedge clock);
    chk(mode, AGSD_MODE_SW);
    repeat (2) @(negedge clock);
    chk(mode, AGSD_MODE_HW);
    $display("latency test done");
    // reset in mid-run, then the held straps pass through again
    @(posedge clock) sys_rst <= 1;
    repeat (2) @(negedge clock);
    chk(gain, {10'h03c, 10'h0c0, 10'h0fc});
    chk(mode, AGSD_MODE_HW);
    @(posedge clock) sys_rst <= 0;
    repeat (2) @(negedge clock);
    chk(gain, {10'h03c, 10'h0c0, 10'h0fc});
    repeat (2) @(negedge clock);
    chk(gain, rows[2].g);
    $display("mid-run reset test done");
    stop_test;
  end
endmodule // tb_top

// *** src/agsd_pkg.sv ***
// package for the gain strap decode block
package agsd_pkg;
  // gain values in tenths of a decibel
  localparam logic [1:0] AGSD_CODE_LOW = 2'h0;
  localparam logic [1:0] AGSD_CODE_MID = 2'h1;
  localparam logic [1:0] AGSD_CODE_HIGH = 2'h2;
  localparam logic [1:0] AGSD_CODE_SW = 2'h3;
  localparam logic [9:0] AGSD_ANA_LOW_DT = 10'h0c0;
  localparam logic [9:0] AGSD_ANA_MID_DT = 10'h0e2;
  localparam logic [9:0] AGSD_ANA_HIGH_DT = 10'h0fa;
  localparam logic [9:0] AGSD_BOOST_DT = 10'h03c;
  localparam logic [9:0] AGSD_VOLUME_RST_DT = 10'h000;
  localparam logic [1:0] AGSD_STRAP_RST = 2'h0;

  typedef enum logic [1:0] {
    AGSD_MODE_HW = 2'b00,
    AGSD_MODE_SW = 2'b01
  } agsd_mode_t;

  typedef struct packed {
    logic [9:0] digital_path_gain;
    logic [9:0] analog_stage_gain;
    logic [9:0] total_gain;
  } agsd_gain_t;
endpackage

// *** src/agsd_top.sv ***
// gain strap decoder and control pin steering
`timescale 1ns/100ps
// Functional notes
// - hardware mode gain follows the strap code
// - code 11 selects software mode gains
// - codes map to 19.2, 22.6, 25 dBV
// - boost fixed at plus six in hardware
// - volume resets zero, fixed in hardware
// - total is digital gain then analog gain
// - software mode routes pins to control port
module agsd_top
  import agsd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // board straps
  input wire logic gain_select_strap_high,
  input wire logic gain_select_strap_low,
  // shared mode pins
  input wire logic mono_mode_or_serial_clock_pin,
  input wire logic switch_rate_or_serial_data_pin,
  // gains from the control port in software mode
  input wire logic [9:0] sw_digital_boost,
  input wire logic [9:0] sw_digital_volume,
  input wire logic [9:0] sw_analog_gain,
  // decoded outputs
  output agsd_mode_t mode,
  output agsd_gain_t gain,
  output logic [9:0] digital_volume,
  output logic mono_mode_enable,
  output logic switch_rate_low,
  output logic ctrl_scl_in,
  output logic ctrl_sda_in
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers, shared by the next-state logic and the reset values

  // the only strap code that hands gain control to the host
  function automatic logic agsd_is_sw_code(
    input logic [1:0] code
  );
    agsd_is_sw_code = (code == AGSD_CODE_SW);
  endfunction

  // analog stage gain for one strap code
  function automatic logic [9:0] agsd_analog_for_code(
    input logic [1:0] code
  );
    logic [9:0] result;
    result = AGSD_ANA_LOW_DT;
    unique case (code)
      AGSD_CODE_LOW: begin
        result = AGSD_ANA_LOW_DT;
      end
      AGSD_CODE_MID: begin
        result = AGSD_ANA_MID_DT;
      end
      AGSD_CODE_HIGH: begin
        result = AGSD_ANA_HIGH_DT;
      end
      AGSD_CODE_SW: begin
        // no hardware gain here; the caller takes the host value
        result = AGSD_ANA_LOW_DT;
      end
    endcase
    agsd_analog_for_code = result;
  endfunction

  // gains in tenths of a decibel simply add
  // wraps at ten bits: the host must keep its sums in range
  function automatic logic [9:0] agsd_db_sum(
    input logic [9:0] first,
    input logic [9:0] second
  );
    logic [10:0] wide;
    wide = {1'b0, first} + {1'b0, second};
    agsd_db_sum = wide[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strap synchroniser
  logic [1:0] strap_meta_r;
  logic [1:0] strap_sync_r;

  // first stage read only by the second; straps are board levels
  // but may still settle while the board powers up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_meta_r <= AGSD_STRAP_RST;
    end else begin
      strap_meta_r <= {gain_select_strap_high,
                       gain_select_strap_low};
    end
  end

  // only this stage feeds the decode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_sync_r <= AGSD_STRAP_RST;
    end else begin
      strap_sync_r <= strap_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state decode
  logic sw_code;
  agsd_mode_t mode_nxt;
  agsd_gain_t gain_nxt;
  logic [9:0] volume_nxt;
  logic [9:0] digital_nxt;
  logic [9:0] analog_nxt;

  assign sw_code = agsd_is_sw_code(strap_sync_r);

  always_comb begin
    if (sw_code) begin
      mode_nxt = AGSD_MODE_SW;
    end else begin
      mode_nxt = AGSD_MODE_HW;
    end
  end

  // volume only leaves its reset value when the host owns the gain
  always_comb begin
    if (sw_code) begin
      volume_nxt = sw_digital_volume;
    end else begin
      volume_nxt = AGSD_VOLUME_RST_DT;
    end
  end

  // boost is trusted as given: the host keeps it steady
  // hardware mode adds the fixed boost to the volume at its reset value
  always_comb begin
    if (sw_code) begin
      digital_nxt = agsd_db_sum(sw_digital_boost, sw_digital_volume);
    end else begin
      digital_nxt = agsd_db_sum(AGSD_BOOST_DT,
                                AGSD_VOLUME_RST_DT);
    end
  end

  // straps pick one of three analog gains; code 11 defers to the host
  always_comb begin
    if (sw_code) begin
      analog_nxt = sw_analog_gain;
    end else begin
      analog_nxt = agsd_analog_for_code(strap_sync_r);
    end
  end

  // digital stage feeds the analog stage, so the decibels add
  always_comb begin
    gain_nxt.digital_path_gain = digital_nxt;
    gain_nxt.analog_stage_gain = analog_nxt;
    gain_nxt.total_gain = agsd_db_sum(digital_nxt, analog_nxt);
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers
  // all taken on one edge, so no output ever mixes two strap codes

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode <= AGSD_MODE_HW;
    end else begin
      mode <= mode_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gain.digital_path_gain <= AGSD_BOOST_DT;
      gain.analog_stage_gain <= AGSD_ANA_LOW_DT;
      gain.total_gain <= agsd_db_sum(AGSD_BOOST_DT, AGSD_ANA_LOW_DT);
    end else begin
      gain.digital_path_gain <= gain_nxt.digital_path_gain;
      gain.analog_stage_gain <= gain_nxt.analog_stage_gain;
      gain.total_gain <= gain_nxt.total_gain;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      digital_volume <= AGSD_VOLUME_RST_DT;
    end else begin
      digital_volume <= volume_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin steering
  // uses the registered mode, so it changes on the same edge as the gains
  // idle control lines sit high so the port never sees a false start
  // limitation: the shared pins get no filtering of their own here
  always_comb begin
    mono_mode_enable = 1'b0;
    switch_rate_low = 1'b0;
    ctrl_scl_in = 1'b1;
    ctrl_sda_in = 1'b1;
    if (mode == AGSD_MODE_SW) begin
      ctrl_scl_in = mono_mode_or_serial_clock_pin;
      ctrl_sda_in = switch_rate_or_serial_data_pin;
    end else begin
      mono_mode_enable = mono_mode_or_serial_clock_pin;
      switch_rate_low = ~switch_rate_or_serial_data_pin;
    end
  end

endmodule // agsd_top
